// >>> rtl/irq_priority.sv
// interrupt request, mask and priority resolution with avalon register access
//
// Implementation choice: the Avalon-MM interface to the registers.
`include "irq_prio_map.svh"

module irq_priority
  import irq_prio_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TA_MATCH_CAP,
  input wire logic TA_OVERFLOW,
  input wire logic TB_MATCH,
  input wire logic [7:2] LVL_REQ,
  output logic CORE_IRQ_VALID,
  output logic [2:0] CORE_IRQ_LEVEL,
  output logic [15:0] INSTR_POINTER
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ptr_hi_q;
  logic [7:0] ptr_lo_q;
  logic [7:0] prio_q;
  logic [7:0] mask_q;
  logic [1:0] ta_pend_q;
  logic [1:0] ta_pend_d;
  logic [7:0] req_q;
  logic [7:0] req_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_vld_q;
  logic [2:0] irq_lvl_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  bus_req_t req;
  wire aligned = (AVS_ADDRESS[1:0] == 2'b00);
  wire [7:0] idx = AVS_ADDRESS[9:2];
  wire idx_known = (idx == `IDX_PTR_HIGH) || (idx == `IDX_PTR_LOW) ||
                   (idx == `IDX_REQ_STATUS) || (idx == `IDX_MASK) ||
                   (idx == `IDX_TA_PEND) || (idx == `IDX_PRIO_CFG);
  assign req.rd = AVS_READ;
  assign req.wr = AVS_WRITE;
  assign req.idx = idx;
  assign req.hit = aligned && idx_known;
  assign req.wdata = AVS_WRITEDATA[7:0];

  // a write commits only at the edge where waitrequest is seen low
  wire commit = req.wr && !wait_q && req.hit && AVS_BYTEENABLE[0];
  wire start = (req.rd || req.wr) && wait_q;
  wire wr_ptr_hi = commit && (req.idx == `IDX_PTR_HIGH);
  wire wr_ptr_lo = commit && (req.idx == `IDX_PTR_LOW);
  wire wr_mask = commit && (req.idx == `IDX_MASK);
  wire wr_ta = commit && (req.idx == `IDX_TA_PEND);
  wire wr_prio = commit && (req.idx == `IDX_PRIO_CFG);

  // read mux; unmapped or misaligned addresses read as zero
  wire [7:0] rd_byte =
    !req.hit ? `RST_BYTE :
    (req.idx == `IDX_PTR_HIGH) ? ptr_hi_q :
    (req.idx == `IDX_PTR_LOW) ? ptr_lo_q :
    (req.idx == `IDX_REQ_STATUS) ? req_q :
    (req.idx == `IDX_MASK) ? mask_q :
    (req.idx == `IDX_TA_PEND) ? {6'h00, ta_pend_q} :
    prio_q;
  assign rdata_d = start && req.rd ? {24'h000000, rd_byte} : `RST_WORD;

  // ----------------------------------------------------------------
  // timer A pending flags
  // ----------------------------------------------------------------
  // set beats clear so an event in the clearing cycle is kept
  wire [1:0] ta_evt = {TA_MATCH_CAP, TA_OVERFLOW};
  wire [1:0] ta_clr = wr_ta ? ~req.wdata[1:0] : 2'b00;
  assign ta_pend_d = (ta_pend_q & ~ta_clr) | ta_evt;

  // ----------------------------------------------------------------
  // request status
  // ----------------------------------------------------------------
  assign req_d = {LVL_REQ, TB_MATCH, |ta_pend_q};

  // ----------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------
  // order of two candidates: b wins when it alone is valid or when preferred
  function automatic cand_t pick(input cand_t a, input cand_t b, input logic pref_b);
    pick = (b.vld && (pref_b || !a.vld)) ? b : a;
  endfunction

  // masked levels drop out before ranking
  wire [7:0] live = req_q & mask_q;

  cand_t c0, c1, c2, c3, c4, c5, c6, c7;
  assign c0 = '{live[0], 3'd0};
  assign c1 = '{live[1], 3'd1};
  assign c2 = '{live[2], 3'd2};
  assign c3 = '{live[3], 3'd3};
  assign c4 = '{live[4], 3'd4};
  assign c5 = '{live[5], 3'd5};
  assign c6 = '{live[6], 3'd6};
  assign c7 = '{live[7], 3'd7};

  // group membership follows the fixed level split
  cand_t win_a, pair_b, win_b, pair_c, win_c;
  assign win_a = pick(c0, c1, prio_q[`PRIO_GRPA]);
  assign pair_b = pick(c3, c4, prio_q[`PRIO_SUBB]);
  assign win_b = pick(c2, pair_b, prio_q[`PRIO_GRPB]);
  assign pair_c = pick(c6, c7, prio_q[`PRIO_SUBC]);
  assign win_c = pick(c5, pair_c, prio_q[`PRIO_GRPC]);

  // group order; undefined codes fall back to A, B, C so the output stays sane
  grp_order_t order;
  assign order = grp_order_t'({prio_q[`PRIO_GRP_HI], prio_q[`PRIO_GRP_MID],
                               prio_q[`PRIO_GRP_LO]});

  cand_t first, second, third, top;
  always_comb begin
    first = win_a;
    second = win_b;
    third = win_c;
    case (order)
      GRP_BCA: begin
        first = win_b;
        second = win_c;
        third = win_a;
      end
      GRP_BAC: begin
        first = win_b;
        second = win_a;
        third = win_c;
      end
      GRP_CAB: begin
        first = win_c;
        second = win_a;
        third = win_b;
      end
      GRP_CBA: begin
        first = win_c;
        second = win_b;
        third = win_a;
      end
      GRP_ACB: begin
        first = win_a;
        second = win_c;
        third = win_b;
      end
      default: begin
        first = win_a;
        second = win_b;
        third = win_c;
      end
    endcase
  end

  // highest ranked survivor goes to the core
  assign top = first.vld ? first : (second.vld ? second : third);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // clock enable low freezes every flop, bus handshake included
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ptr_hi_q <= `RST_BYTE;
      ptr_lo_q <= `RST_BYTE;
      prio_q <= `RST_BYTE;
      mask_q <= `RST_BYTE;
    end else if (CLK_EN) begin
      if (wr_ptr_hi) begin
        ptr_hi_q <= req.wdata;
      end
      if (wr_ptr_lo) begin
        ptr_lo_q <= req.wdata;
      end
      if (wr_prio) begin
        prio_q <= req.wdata;
      end
      if (wr_mask) begin
        mask_q <= req.wdata;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ta_pend_q <= 2'b00;
      req_q <= `RST_BYTE;
      irq_vld_q <= 1'b0;
      irq_lvl_q <= 3'd0;
    end else if (CLK_EN) begin
      ta_pend_q <= ta_pend_d;
      req_q <= req_d;
      irq_vld_q <= top.vld;
      irq_lvl_q <= top.vld ? top.lvl : 3'd0;
    end
  end

  // one wait cycle, then a single low cycle that completes the transfer
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wait_q <= 1'b1;
      rdata_q <= `RST_WORD;
    end else if (CLK_EN) begin
      wait_q <= !start;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign CORE_IRQ_VALID = irq_vld_q;
  assign CORE_IRQ_LEVEL = irq_lvl_q;
  assign INSTR_POINTER = {ptr_hi_q, ptr_lo_q};

endmodule

// >>> rtl/irq_prio_map.svh
// register map, field positions and reset values for the interrupt priority block
`ifndef IRQ_PRIO_MAP_SVH
`define IRQ_PRIO_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PTR_HIGH 8'hDA
`define IDX_PTR_LOW 8'hDB
`define IDX_REQ_STATUS 8'hDC
`define IDX_MASK 8'hDD
`define IDX_TA_PEND 8'hF4
`define IDX_PRIO_CFG 8'hFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PRIO_GRP_HI 7
`define PRIO_SUBC 6
`define PRIO_GRPC 5
`define PRIO_GRP_MID 4
`define PRIO_SUBB 3
`define PRIO_GRPB 2
`define PRIO_GRP_LO 1
`define PRIO_GRPA 0
`define TA_PEND_OVF 0
`define TA_PEND_MC 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

`endif

// >>> rtl/irq_prio_pkg.sv
// types shared by the interrupt priority block
package irq_prio_pkg;

  // group orderings selected by the three group bits
  typedef enum logic [2:0] {
    GRP_UNDEF0 = 3'b000,
    GRP_BCA = 3'b001,
    GRP_ABC = 3'b010,
    GRP_BAC = 3'b011,
    GRP_CAB = 3'b100,
    GRP_CBA = 3'b101,
    GRP_ACB = 3'b110,
    GRP_UNDEF7 = 3'b111
  } grp_order_t;

  // a candidate level: valid flag and level number
  typedef struct packed {
    logic vld;
    logic [2:0] lvl;
  } cand_t;

  // one avalon request as seen by the slave
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] idx;
    logic hit;
    logic [7:0] wdata;
  } bus_req_t;

endpackage

// >>> sim/irq_priority_monitor.sv
// assertions on the register bus and core request ports
module irq_priority_monitor (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic TB_MATCH,
  input wire logic [7:2] LVL_REQ,
  input wire logic CORE_IRQ_VALID,
  input wire logic [2:0] CORE_IRQ_LEVEL,
  input wire logic [15:0] INSTR_POINTER
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // request history
  // ----------------
  // two deep: a level reaches the core two edges after it is sampled
  logic [7:1] req_d1_q, req_d2_q;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      req_d1_q <= 7'h00;
      req_d2_q <= 7'h00;
    end else begin
      req_d1_q <= {LVL_REQ, TB_MATCH};
      req_d2_q <= req_d1_q;
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer");
  a_idle_wait: assert property (!(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer without request");
  a_one_wait: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_rdata_idle: assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h0000_0000)
    else $error("read data outside answer");
  a_level_idle: assert property (!CORE_IRQ_VALID |-> CORE_IRQ_LEVEL == 3'h0)
    else $error("level without valid");
  a_core_cause: assert property (CORE_IRQ_VALID && CORE_IRQ_LEVEL != 3'h0 |-> req_d2_q[CORE_IRQ_LEVEL])
    else $error("core level not requested");
  a_ptr_hold: assert property (AVS_WAITREQUEST |=> $stable(INSTR_POINTER))
    else $error("pointer moved without write");
  a_ptr_write: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == 10'h368
    |=> INSTR_POINTER[15:8] == $past(AVS_WRITEDATA[7:0])) else $error("pointer high not written");
endmodule

// >>> sim/irq_source_model.sv
// model of the interrupt sources: timer events and level requests
module irq_source_model (
  input wire logic clk,
  input wire logic [1:0] fire,
  input wire logic [7:1] req,
  output logic ta_ovf = 1'b0,
  output logic ta_mc = 1'b0,
  output logic tb_m = 1'b0,
  output logic [7:2] lvl = 6'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] fire_q = 2'b00;
  // timer events are one-cycle pulses, so a held fire bit fires once
  always @(posedge clk) begin
    fire_q <= fire;
    ta_ovf <= fire[0] & ~fire_q[0];
    ta_mc <= fire[1] & ~fire_q[1];
    {lvl, tb_m} <= req;
  end
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the interrupt priority block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [1:0] fire = 2'b00;
  logic [7:1] req = 7'h00;
  logic [31:0] rdata;
  logic waitreq, ta_ovf, ta_mc, tb_m, vld;
  logic [7:2] lvl;
  logic [2:0] irq_lvl;
  logic [15:0] ptr;
  int failures = 0;
  int check_count = 0;
  // config, requests 7:1, winner
  logic [23:0] tab [9] = '{24'h02FE02, 24'h06FE03, 24'h0EFE04, 24'h10FE01, 24'h12E201,
    24'h80FE05, 24'hE2FE07, 24'hB0FC06, 24'h801C02};
  irq_priority u_irq_priority (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .TA_MATCH_CAP(ta_mc), .TA_OVERFLOW(ta_ovf), .TB_MATCH(tb_m),
    .LVL_REQ(lvl), .CORE_IRQ_VALID(vld), .CORE_IRQ_LEVEL(irq_lvl), .INSTR_POINTER(ptr));
  irq_source_model u_irq_source_model (.clk(ref_clk), .fire(fire), .req(req), .ta_ovf(ta_ovf),
    .ta_mc(ta_mc), .tb_m(tb_m), .lvl(lvl));
  always #12.5 ref_clk = ~ref_clk;
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a read compares against d, a write sends d
  // no cycle limit here: only the watchdog ends a wait that never completes
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input string what);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
    end while (waitreq !== 1'b0);
    if (!w) chk(what, {8'h00, d}, rdata[15:0]);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_status_mask;
    bus(0, 10'h370, 8'h00, "status reset");
    req <= 7'h7F;
    repeat (4) @(posedge ref_clk);
    bus(1, 10'h370, 8'h00, "");
    bus(0, 10'h370, 8'hFE, "status raised");
    chk("core all masked", 16'h0000, {12'h000, vld, irq_lvl});
    $display("test status_mask done");
  endtask
  task automatic t_priority;
    for (int i = 0; i < 9; i++) begin
      bus(1, 10'h3FC, tab[i][23:16], "");
      bus(0, 10'h3FC, tab[i][23:16], "priority");
      if (i == 0) bus(1, 10'h374, 8'hFF, "");
      req <= tab[i][15:9];
      repeat (4) @(posedge ref_clk);
      chk("winner", {12'h000, 1'b1, tab[i][2:0]}, {12'h000, vld, irq_lvl});
    end
    $display("test priority done");
  endtask
  task automatic t_timer;
    req <= 7'h7F;
    bus(1, 10'h3FC, 8'h10, "");
    fire <= 2'b11;
    repeat (4) @(posedge ref_clk);
    bus(0, 10'h3D0, 8'h03, "timer pending");
    bus(0, 10'h370, 8'hFF, "status level 0");
    chk("level 0 wins", 16'h0008, {12'h000, vld, irq_lvl});
    bus(1, 10'h3FC, 8'h11, "");
    repeat (2) @(posedge ref_clk);
    chk("level 1 wins", 16'h0009, {12'h000, vld, irq_lvl});
    bus(1, 10'h3FC, 8'h10, "");
    bus(1, 10'h374, 8'hFE, "");
    repeat (2) @(posedge ref_clk);
    chk("level 0 masked", 16'h0009, {12'h000, vld, irq_lvl});
    bus(1, 10'h3D0, 8'h02, "");
    bus(0, 10'h3D0, 8'h02, "overflow cleared");
    bus(1, 10'h3D0, 8'h00, "");
    fire <= 2'b00;
    req <= 7'h00;
    repeat (4) @(posedge ref_clk);
    bus(0, 10'h370, 8'h00, "status clear");
    chk("core idle", 16'h0000, {12'h000, vld, irq_lvl});
    $display("test timer done");
  endtask
  task automatic t_pointer;
    bus(1, 10'h368, 8'hA5, "");
    bus(1, 10'h36C, 8'h3C, "");
    @(posedge ref_clk);
    chk("pointer", 16'hA53C, ptr);
    be <= 4'h0;
    bus(1, 10'h36C, 8'hFF, "");
    be <= 4'hF;
    bus(0, 10'h36C, 8'h3C, "pointer low");
    bus(0, 10'h368, 8'hA5, "pointer high");
    bus(0, 10'h300, 8'h00, "unmapped");
    $display("test pointer done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_status_mask();
    t_priority();
    t_timer();
    t_pointer();
    finish_test();
  end
  // the tests need well under 2000 cycles
  initial begin
    #50us;
    failures++;
    finish_test();
  end
endmodule
bind irq_priority irq_priority_monitor u_irq_priority_monitor (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TB_MATCH(TB_MATCH), .LVL_REQ(LVL_REQ),
  .CORE_IRQ_VALID(CORE_IRQ_VALID), .CORE_IRQ_LEVEL(CORE_IRQ_LEVEL), .INSTR_POINTER(INSTR_POINTER));
